// File: fcft_pkg.sv
/*
 * shared constants, state type and code functions for the fax control
 * frame and training block.
 * assumes a 250 MHz reference clock; octets are held with b1 in bit 7.
 */
package fcft_pkg;

	// ---------------------------------------------------------------
	// frame octets and facsimile control codes (b1 in bit 7)
	// ---------------------------------------------------------------
	localparam logic [7:0]  FLAG_OCT   = 8'h7E;
	localparam logic [7:0]  ADDR_OCT   = 8'hFF;
	localparam logic [7:0]  CTRL_OCT   = 8'hC0;
	localparam logic [7:0]  CTRL_FINAL = 8'h08;
	localparam logic [7:0]  XBIT       = 8'h80;
	localparam logic [7:0]  TCF_OCT    = 8'h00;
	localparam logic [7:0]  FCF_DIS    = 8'h01;
	localparam logic [7:0]  FCF_DCS    = 8'h41;
	localparam logic [7:0]  FCF_CFR    = 8'h21;
	localparam logic [7:0]  FCF_FTT    = 8'h22;
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam logic [15:0] CRC_POLY   = 16'h1021;
	localparam logic [15:0] CRC_GOOD   = 16'h1D0F;
	localparam logic [2:0]  BIT_LAST   = 3'h7;
	localparam logic [3:0]  RX_MIN_OCT = 4'h5;
	localparam logic [3:0]  RX_IDX_MAX = 4'hF;

	// ---------------------------------------------------------------
	// modem rates and timing
	// ---------------------------------------------------------------
	localparam logic [1:0]  RATE_2400 = 2'h0;
	localparam logic [1:0]  RATE_4800 = 2'h1;
	localparam logic [1:0]  RATE_HS   = 2'h2;
	localparam logic [1:0]  RATE_V34  = 2'h3;
	localparam int          V34_MAX_BPS   = 33600;
	localparam int          CLK_KHZ       = 250000;
	localparam int          TRAIN_4800_MS = 923;
	localparam int          TRAIN_2400_MS = 1158;
	localparam int          TRAIN_HS_MS   = 100;
	localparam int          TCF_MS        = 1500;
	localparam logic [31:0] TRAIN_4800_CYC = 32'(TRAIN_4800_MS * CLK_KHZ);
	localparam logic [31:0] TRAIN_2400_CYC = 32'(TRAIN_2400_MS * CLK_KHZ);
	localparam logic [31:0] TRAIN_HS_CYC   = 32'(TRAIN_HS_MS * CLK_KHZ);
	localparam logic [31:0] TCF_CYC        = 32'(TCF_MS * CLK_KHZ);
	localparam int          FIF_W  = 8;
	localparam int          FIFO_D = 32;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_FLAG1 = 4'b0001,
		ST_ADDR  = 4'b0010,
		ST_CTRL  = 4'b0011,
		ST_FCF   = 4'b0100,
		ST_FIF   = 4'b0101,
		ST_FCS1  = 4'b0110,
		ST_FCS2  = 4'b0111,
		ST_FLAG2 = 4'b1000,
		ST_TRAIN = 4'b1001,
		ST_TCF   = 4'b1010
	} fcft_st_t;

	// ---------------------------------------------------------------
	// code functions
	// ---------------------------------------------------------------
	// crc-16, 0x1021, fed b1 first
	function automatic logic [15:0] fcft_crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : fcft_crc_byte

	// codes whose b1 is the direction bit
	function automatic logic fcft_has_x(input logic [7:0] c);
		case (c & ~XBIT)
			8'h44, 8'h42, 8'h41, 8'h21, 8'h22, 8'h71, 8'h72, 8'h74,
			8'h31, 8'h32, 8'h35, 8'h34, 8'h43, 8'h45, 8'h5F, 8'h76,
			8'h37, 8'h3D, 8'h7D, 8'h48, 8'h23, 8'h73, 8'h38,
			8'h33: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : fcft_has_x

	function automatic logic fcft_known(input logic [7:0] c);
		case (c)
			8'h04, 8'h84, 8'h02, 8'h82, 8'h01, 8'h81, 8'h85,
			8'h83: return 1'b1;
			default: return fcft_has_x(c);
		endcase
	endfunction : fcft_known

endpackage : fcft_pkg

// File: fcft_fifo.sv
/*
 * parameterised synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module fcft_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         ref_clk,   // clock
	input  wire logic         rst_b,     // sync reset, low
	input  wire logic [W-1:0] in_data,   // fill data
	input  wire logic         in_valid,  // fill valid
	output logic              in_ready,  // room available
	output logic [W-1:0]      out_data,  // head word
	output logic              out_valid, // head valid
	input  wire logic         out_ready  // drain accepts
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          push;
	logic          pop;

	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rd_q];

	// count next value, ready is registered so full is exact
	always_comb begin
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wr_q     <= '0;
			rd_q     <= '0;
			cnt_q    <= '0;
			in_ready <= 1'b0;
		end else begin
			wr_q     <= push ? AW'((wr_q + 1'b1) % D) : wr_q;
			rd_q     <= pop ? AW'((rd_q + 1'b1) % D) : rd_q;
			cnt_q    <= cnt_d;
			in_ready <= (cnt_d < CW'(D));
		end
	end

	// storage, no reset needed
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

endmodule : fcft_fifo

// File: fcft_core.sv
/*
 * fax control frame builder/checker with training and tcf sequencing.
 * assumes a modem that takes and gives one bit per valid/ready beat and
 * flags the tcf reception window; no zero-bit insertion is done here.
 */
// Overview of operation
// - frames open with flag, all-ones address, control with final bit.
// - control field carries a fixed eight-bit code; unknown codes rejected.
// - after receiving DIS, direction bit is one in every sent code that has one.
// - after receiving the reply to our DIS, direction bit is zero.
// - after DCS, training follows at the rate DCS selected, except at the V.34 rate, where none is sent.
// - training lasts 923 ms at 4800 bps, 1158 ms at 2400 bps.
// - a TCF check pattern precedes any picture data.
// - TCF is all zeros for 1.5 s at the training rate.
// - a TCF with any error is answered with FTT.
// - an error-free TCF is answered with CFR.
// - high-speed mode uses the V.34 modem, at most 33.6 kbps.
// - each frame ends with an FCS over address through FIF.
`timescale 1ns/1ps
module fcft_core
	import fcft_pkg::*;
#(
	parameter logic [31:0] T4800_CYC = TRAIN_4800_CYC,
	parameter logic [31:0] T2400_CYC = TRAIN_2400_CYC,
	parameter logic [31:0] THS_CYC   = TRAIN_HS_CYC,
	parameter logic [31:0] TTCF_CYC  = TCF_CYC
) (
	input  wire logic             ref_clk,       // 250 MHz clock
	input  wire logic             rst_b,         // sync reset, low
	input  wire logic             tx_req,        // send request pulse
	input  wire logic [7:0]       tx_code,       // facsimile control code
	input  wire logic             tx_final,      // last frame of group
	input  wire logic             tx_has_fif,    // fif from fifo follows
	input  wire logic [1:0]       tx_rate,       // rate chosen by dcs
	input  wire logic [FIF_W-1:0] fif_in_data,   // fif octet
	input  wire logic             fif_in_last,   // last fif octet
	input  wire logic             fif_in_valid,  // fif octet valid
	output logic                  fif_in_ready,  // fifo has room
	output logic                  tx_bit,        // serial bit to modem
	output logic                  tx_bit_valid,  // bit valid
	input  wire logic             tx_bit_ready,  // modem takes bit
	output logic                  mdm_train,     // send training
	output logic                  mdm_tcf,       // send tcf zeros
	output logic [1:0]            mdm_rate,      // modem rate
	output logic                  mdm_v34,       // high-speed mode
	output logic                  tx_busy,       // frame in progress
	output logic                  tx_done,       // frame sent pulse
	output logic                  tx_reject,     // unknown code pulse
	input  wire logic             rx_bit,        // serial bit in
	input  wire logic             rx_bit_valid,  // rx bit strobe
	input  wire logic             rx_tcf_active, // tcf window level
	output logic                  rx_frame_ok,   // good frame pulse
	output logic                  rx_frame_err,  // bad frame pulse
	output logic [7:0]            rx_fcf,        // last good code
	output logic                  rx_final,      // last good final bit
	output logic                  tcf_pass,      // tcf clean pulse
	output logic                  tcf_fail       // tcf error pulse
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	fcft_st_t    st_q, st_d;
	logic [7:0]  sh_q, byte_d, cur_fcf_q;
	logic [15:0] crc_q, rx_crc_q;
	logic [31:0] tmr_q, tmr_d, train_cyc;
	logic [2:0]  bcnt_q, rx_cnt_q;
	logic [3:0]  rx_idx_q;
	logic [7:0]  rx_sh_d;
	logic [8:0]  fifo_out;
	logic        fifo_valid, pop, load, stall, adv, start, ok_end;
	logic        wait_q, fif_more_q, cur_final_q, x_q, dis_sent_q;
	logic        resp_pend_q, resp_ftt_q, tcf_err_q, tcf_prev_q;
	logic        in_frame_q, rx_hdr_ok_q, rx_known_q, rx_fin_q;
	logic [7:0]  rx_code_q;

	fcft_fifo #(.W(FIF_W + 1), .D(FIFO_D)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.in_data   ({fif_in_last, fif_in_data}),
		.in_valid  (fif_in_valid),
		.in_ready  (fif_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (pop)
	);

	assign tx_bit = sh_q[7];  // b1 leaves first
	assign start  = (st_q == ST_IDLE) & (resp_pend_q |
		(tx_req & fcft_known(tx_code)));

	// training length by selected rate
	always_comb begin
		case (mdm_rate)
			RATE_4800: train_cyc = T4800_CYC;
			RATE_2400: train_cyc = T2400_CYC;
			default:   train_cyc = THS_CYC;
		endcase
	end

	// ---------------------------------------------------------------
	// transmit sequencer
	// ---------------------------------------------------------------
	// one octet is loaded as the last bit of the previous one is taken
	always_comb begin
		st_d   = st_q;
		byte_d = sh_q;
		tmr_d  = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
		load   = 1'b0;
		pop    = 1'b0;
		stall  = 1'b0;
		adv    = wait_q | (tx_bit_valid & tx_bit_ready &
			(bcnt_q == BIT_LAST));
		case (st_q)
			ST_IDLE: if (start) begin
				st_d   = ST_FLAG1;
				byte_d = FLAG_OCT;
				load   = 1'b1;
			end
			ST_FLAG1: if (adv) begin
				st_d   = ST_ADDR;
				byte_d = ADDR_OCT;
				load   = 1'b1;
			end
			ST_ADDR: if (adv) begin
				st_d   = ST_CTRL;
				byte_d = cur_final_q ? (CTRL_OCT | CTRL_FINAL) : CTRL_OCT;
				load   = 1'b1;
			end
			ST_CTRL: if (adv) begin
				st_d   = ST_FCF;
				load   = 1'b1;
				byte_d = cur_fcf_q;
				if (fcft_has_x(cur_fcf_q)) begin
					byte_d = x_q ? (cur_fcf_q | XBIT) : (cur_fcf_q & ~XBIT);
				end
			end
			ST_FCF, ST_FIF: if (adv) begin
				if (!fif_more_q) begin
					st_d   = ST_FCS1;
					byte_d = ~crc_q[15:8];
					load   = 1'b1;
				end else if (fifo_valid) begin
					st_d   = ST_FIF;
					byte_d = fifo_out[7:0];
					load   = 1'b1;
					pop    = 1'b1;
				end else begin
					stall  = 1'b1;  // underrun: hold the line idle
				end
			end
			ST_FCS1: if (adv) begin
				st_d   = ST_FCS2;
				byte_d = ~crc_q[7:0];
				load   = 1'b1;
			end
			ST_FCS2: if (adv) begin
				st_d   = ST_FLAG2;
				byte_d = FLAG_OCT;
				load   = 1'b1;
			end
			ST_FLAG2: if (adv) begin
				// requested code may carry either x, so compare without it
				if ((cur_fcf_q & ~XBIT) == FCF_DCS && mdm_rate != RATE_V34) begin
					st_d  = ST_TRAIN;
					tmr_d = train_cyc;
				end else begin
					st_d  = ST_IDLE;
				end
			end
			ST_TRAIN: if (tmr_q <= 32'h1) begin
				st_d   = ST_TCF;
				tmr_d  = TTCF_CYC;
				byte_d = TCF_OCT;
				load   = 1'b1;
			end
			ST_TCF: if (tmr_q <= 32'h1) begin
				st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// state, timer and serializer
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_q         <= ST_IDLE;
			tmr_q        <= '0;
			sh_q         <= '0;
			bcnt_q       <= '0;
			tx_bit_valid <= 1'b0;
			wait_q       <= 1'b0;
		end else begin
			st_q   <= st_d;
			tmr_q  <= tmr_d;
			wait_q <= stall;
			if (load) begin
				sh_q   <= byte_d;
				bcnt_q <= '0;
			end else if (tx_bit_valid && tx_bit_ready) begin
				sh_q   <= {sh_q[6:0], 1'b0};
				bcnt_q <= bcnt_q + 1'b1;
			end
			if (load || st_d == ST_TCF) begin
				tx_bit_valid <= 1'b1;
			end else if (stall || st_d == ST_IDLE || st_d == ST_TRAIN) begin
				tx_bit_valid <= 1'b0;
			end
		end
	end

	// frame parameters, crc and status
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cur_fcf_q <= '0; cur_final_q <= 1'b0; fif_more_q <= 1'b0;
			crc_q     <= CRC_INIT; mdm_rate <= RATE_2400; mdm_v34 <= 1'b0;
			tx_busy   <= 1'b0; tx_done <= 1'b0; tx_reject <= 1'b0;
			mdm_train <= 1'b0; mdm_tcf <= 1'b0; dis_sent_q <= 1'b0;
		end else begin
			tx_busy   <= (st_d != ST_IDLE) && (st_d != ST_TRAIN) &&
				(st_d != ST_TCF);
			tx_done   <= (st_q == ST_FLAG2) && adv;
			tx_reject <= (st_q == ST_IDLE) && !resp_pend_q && tx_req &&
				!fcft_known(tx_code);
			mdm_train <= (st_d == ST_TRAIN);
			mdm_tcf   <= (st_d == ST_TCF);
			if (start) begin
				cur_fcf_q   <= resp_pend_q ? (resp_ftt_q ? FCF_FTT : FCF_CFR)
					: tx_code;
				cur_final_q <= resp_pend_q | tx_final;
				fif_more_q  <= !resp_pend_q & tx_has_fif;
				crc_q       <= CRC_INIT;
				if (!resp_pend_q && (tx_code & ~XBIT) == FCF_DCS) begin
					mdm_rate <= tx_rate;
					mdm_v34  <= (tx_rate == RATE_V34);
				end
			end else if (load && st_d inside {ST_ADDR, ST_CTRL, ST_FCF,
				ST_FIF}) begin
				crc_q <= fcft_crc_byte(crc_q, byte_d);
			end
			if (pop && fifo_out[8]) begin
				fif_more_q <= 1'b0;
			end
			if (st_q == ST_FLAG2 && adv && cur_fcf_q == FCF_DIS) begin
				dis_sent_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// tcf check and automatic reply
	// ---------------------------------------------------------------
	// the error flag is set ahead of its clear so a one in the window's first cycle is not lost
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tcf_prev_q <= 1'b0; tcf_err_q <= 1'b0; resp_pend_q <= 1'b0;
			resp_ftt_q <= 1'b0; tcf_pass <= 1'b0; tcf_fail <= 1'b0;
		end else begin
			tcf_prev_q <= rx_tcf_active;
			if (rx_tcf_active && rx_bit_valid && rx_bit) begin
				tcf_err_q <= 1'b1;
			end else if (rx_tcf_active && !tcf_prev_q) begin
				tcf_err_q <= 1'b0;
			end
			tcf_fail <= tcf_prev_q && !rx_tcf_active && tcf_err_q;
			tcf_pass <= tcf_prev_q && !rx_tcf_active && !tcf_err_q;
			if (tcf_prev_q && !rx_tcf_active) begin
				resp_pend_q <= 1'b1;
				resp_ftt_q  <= tcf_err_q;
			end else if (start) begin
				resp_pend_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// receive deframer
	// ---------------------------------------------------------------
	logic [6:0] rx_sh_q_w;
	assign rx_sh_d = {rx_sh_q_w, rx_bit};
	assign ok_end = (rx_idx_q >= RX_MIN_OCT) && (rx_crc_q == CRC_GOOD) &&
		rx_hdr_ok_q && rx_known_q;

	// a flag both closes a frame and opens the next
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rx_sh_q_w <= '0; rx_cnt_q <= '0; rx_idx_q <= '0;
			in_frame_q <= 1'b0; rx_crc_q <= CRC_INIT; rx_hdr_ok_q <= 1'b0;
			rx_known_q <= 1'b0; rx_code_q <= '0; rx_fin_q <= 1'b0;
			rx_frame_ok <= 1'b0; rx_frame_err <= 1'b0; rx_fcf <= '0;
			rx_final <= 1'b0; x_q <= 1'b0;
		end else begin
			rx_frame_ok  <= 1'b0;
			rx_frame_err <= 1'b0;
			if (rx_bit_valid && !rx_tcf_active) begin
				rx_sh_q_w <= rx_sh_d[6:0];
				rx_cnt_q  <= rx_cnt_q + 1'b1;
				if (!in_frame_q || rx_cnt_q == BIT_LAST) begin
					if (rx_sh_d == FLAG_OCT) begin
						if (in_frame_q && rx_idx_q != '0) begin
							rx_frame_ok  <= ok_end;
							rx_frame_err <= !ok_end;
							if (ok_end) begin
								rx_fcf   <= rx_code_q;
								rx_final <= rx_fin_q;
								if (dis_sent_q) x_q <= 1'b0;
								if (rx_code_q == FCF_DIS) x_q <= 1'b1;
							end
						end
						in_frame_q <= 1'b1;
						rx_cnt_q   <= '0;
						rx_idx_q   <= '0;
						rx_crc_q   <= CRC_INIT;
					end else if (in_frame_q) begin
						rx_crc_q <= fcft_crc_byte(rx_crc_q, rx_sh_d);
						rx_idx_q <= (rx_idx_q == RX_IDX_MAX) ? rx_idx_q
							: rx_idx_q + 1'b1;
						case (rx_idx_q)
							4'h0: rx_hdr_ok_q <= (rx_sh_d == ADDR_OCT);
							4'h1: begin
								rx_hdr_ok_q <= rx_hdr_ok_q &&
									((rx_sh_d & ~CTRL_FINAL) == CTRL_OCT);
								rx_fin_q    <= |(rx_sh_d & CTRL_FINAL);
							end
							4'h2: begin
								rx_code_q  <= rx_sh_d;
								rx_known_q <= fcft_known(rx_sh_d);
							end
							default: rx_known_q <= rx_known_q;
						endcase
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	flag_open_a: assert property ($rose(tx_busy) |-> sh_q == FLAG_OCT && tx_bit_valid)
		else $error("frame did not open with flag");
	ctrl_octet_a: assert property ($rose(st_q == ST_CTRL) |-> sh_q == (cur_final_q ? (CTRL_OCT | CTRL_FINAL) : CTRL_OCT))
		else $error("control octet wrong");
	known_code_a: assert property ($rose(tx_busy) |-> fcft_known(cur_fcf_q))
		else $error("unknown code sent");
	xbit_set_a: assert property ($rose(st_q == ST_FCF) && fcft_has_x(cur_fcf_q) && $past(x_q) |-> sh_q[7])
		else $error("direction bit not set");
	xbit_clear_a: assert property ($rose(st_q == ST_FCF) && fcft_has_x(cur_fcf_q) && !$past(x_q) |-> !sh_q[7])
		else $error("direction bit not cleared");
	train_follow_a: assert property (tx_done && (cur_fcf_q & ~XBIT) == FCF_DCS && !mdm_v34 |-> mdm_train && !tx_bit_valid)
		else $error("training did not follow dcs");
	train_len_a: assert property ($rose(mdm_train) |-> tmr_q == train_cyc)
		else $error("training length wrong");
	tcf_order_a: assert property ($fell(mdm_train) |-> mdm_tcf ##1 mdm_tcf)
		else $error("tcf did not follow training");
	tcf_zero_a: assert property (mdm_tcf |-> tx_bit_valid && !tx_bit && tmr_q <= TTCF_CYC)
		else $error("tcf not zero data");
	tcf_ftt_a: assert property (tcf_fail |-> resp_pend_q && resp_ftt_q)
		else $error("tcf error not answered with ftt");
	tcf_cfr_a: assert property (tcf_pass |-> resp_pend_q && !resp_ftt_q)
		else $error("clean tcf not answered with cfr");
	v34_mode_a: assert property (mdm_v34 |-> mdm_rate == RATE_V34 && !mdm_train)
		else $error("v34 mode inconsistent");
	fcs_high_a: assert property ($rose(st_q == ST_FCS1) |-> sh_q == ~crc_q[15:8])
		else $error("fcs high octet wrong");
	bit_order_a: assert property (tx_bit_valid && tx_bit_ready && bcnt_q != BIT_LAST && st_q != ST_TCF |=> tx_bit == $past(sh_q[6]))
		else $error("bit order wrong");

	dcs_train_c: cover property (tx_done && (cur_fcf_q & ~XBIT) == FCF_DCS ##1 mdm_train);
	ftt_reply_c: cover property (tcf_fail ##[1:300] tx_done);
	rx_good_c:   cover property (rx_frame_ok);

endmodule : fcft_core

// File: fcft_remote.sv
/*
 * far-side modem model: takes the serial bit stream with random stalls,
 * keeps the octets it assembles and counts ones seen in the tcf burst.
 * assumes frames are whole octets and tcf bits are flagged by mdm_tcf.
 */
`timescale 1ns/1ps
module fcft_remote (
	input  wire logic ref_clk,      // clock
	input  wire logic tx_bit,       // bit from block
	input  wire logic tx_bit_valid, // bit valid
	input  wire logic mdm_tcf,      // tcf burst level
	output logic      tx_bit_ready  // bit taken
);
	// ------------------------------------------------------------
	// octet capture
	// ------------------------------------------------------------
	logic [7:0] sh;   // octet being assembled
	int         nb;   // bits held in sh
	logic [7:0] q[$]; // octets taken so far
	int         ones; // tcf ones taken
	initial begin
		tx_bit_ready = 1'b0;
		nb = 0;
		ones = 0;
	end
	// stalls about one beat in four, as a slow line modem would
	always @(posedge ref_clk) begin
		if (tx_bit_valid && tx_bit_ready) begin
			if (mdm_tcf) begin
				ones = ones + int'(tx_bit);
			end else begin
				sh = {sh[6:0], tx_bit};
				nb = nb + 1;
				if (nb == 8) begin
					q.push_back(sh);
					nb = 0;
				end
			end
		end
		tx_bit_ready <= ($urandom_range(3) != 0);
	end
endmodule : fcft_remote

// File: fcft_core_tb.sv
/*
 * self-checking bench for fcft_core: random and corner frames, training,
 * tcf replies and fifo fill. assumes fcft_remote as the far modem and
 * shortened training and tcf counts.
 */
`timescale 1ns/1ps
module fcft_core_tb;
	import fcft_pkg::*;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	localparam int T4 = 40, T2 = 50, TH = 30, TT = 60;
	logic ref_clk, rst_b, tx_req, tx_final, tx_has_fif, fif_in_last;
	logic fif_in_valid, fif_in_ready, tx_bit, tx_bit_valid, tx_bit_ready;
	logic mdm_train, mdm_tcf, mdm_v34, tx_busy, tx_done, tx_reject;
	logic rx_bit, rx_bit_valid, rx_tcf_active, rx_frame_ok, rx_frame_err;
	logic rx_final, tcf_pass, tcf_fail, fn0;
	logic [7:0] tx_code, fif_in_data, rx_fcf;
	logic [1:0] tx_rate, mdm_rate;
	logic [7:0] fq[$], eq[$];
	int n_errors = 0, n_checks = 0, c_ok, c_err, c_pas, c_fai, c_rej, n_tr, n_tc;
	int e_tr[4] = '{T2, T4, TH, 0};
	fcft_core #(.T4800_CYC(T4), .T2400_CYC(T2), .THS_CYC(TH),
		.TTCF_CYC(TT)) DUT (.ref_clk, .rst_b, .tx_req, .tx_code, .tx_final,
		.tx_has_fif, .tx_rate, .fif_in_data, .fif_in_last, .fif_in_valid,
		.fif_in_ready, .tx_bit, .tx_bit_valid, .tx_bit_ready, .mdm_train,
		.mdm_tcf, .mdm_rate, .mdm_v34, .tx_busy, .tx_done, .tx_reject,
		.rx_bit, .rx_bit_valid, .rx_tcf_active, .rx_frame_ok, .rx_frame_err,
		.rx_fcf, .rx_final, .tcf_pass, .tcf_fail);
	fcft_remote P (.ref_clk, .tx_bit, .tx_bit_valid, .mdm_tcf, .tx_bit_ready);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// pulse counters, so single-cycle outputs are never missed
	always @(posedge ref_clk) begin
		c_ok += int'(rx_frame_ok === 1'b1);
		c_err += int'(rx_frame_err === 1'b1);
		c_pas += int'(tcf_pass === 1'b1);
		c_fai += int'(tcf_fail === 1'b1);
		c_rej += int'(tx_reject === 1'b1);
		n_tr += int'(mdm_train === 1'b1);
		n_tc += int'(mdm_tcf === 1'b1);
	end
	// ------------------------------------------------------------
	// tasks and expectation functions
	// ------------------------------------------------------------
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// crc over address..fif, msb first
	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			for (int k = 7; k >= 0; k--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? 16'h1021 : 16'h0);
			end
		end
		return c;
	endfunction : crc_of
	// expected octets of a whole frame, flags included
	function automatic void mk(logic [7:0] cd, logic fn, logic bad);
		logic [15:0] c;
		eq = {8'hFF, fn ? 8'hC8 : 8'hC0, cd};
		eq = {eq, fq};
		c = ~crc_of(eq) ^ 16'(bad);
		eq = {8'h7E, eq, c[15:8], c[7:0], 8'h7E};
	endfunction : mk
	task automatic cmp(string nm);
		chk({nm, " len"}, P.q.size(), eq.size());
		foreach (eq[i]) chk(nm, P.q[i], eq[i]);
		$display("test %s done", nm);
	endtask : cmp
	task automatic rx_oct(logic [7:0] o);
		for (int i = 7; i >= 0; i--) begin
			@(posedge ref_clk);
			rx_bit <= o[i];
			rx_bit_valid <= 1'b1;
		end
	endtask : rx_oct
	// release the line with the inverse of its last level
	task automatic rx_end;
		@(posedge ref_clk);
		rx_bit_valid <= 1'b0;
		rx_bit <= ~rx_bit;
		rx_tcf_active <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : rx_end
	task automatic rx_frm(logic [7:0] cd, logic bad);
		fq = {};
		mk(cd, 1'b1, bad);
		foreach (eq[i]) rx_oct(eq[i]);
		rx_end();
	endtask : rx_frm
	task automatic push(logic [7:0] d, logic l);
		fif_in_data <= d;
		fif_in_last <= l;
		fif_in_valid <= 1'b1;
		@(posedge ref_clk);
		while (fif_in_ready !== 1'b1) @(posedge ref_clk);
	endtask : push
	task automatic req(logic [7:0] cd, logic fn, logic [1:0] rt);
		@(posedge ref_clk);
		tx_req <= 1'b1;
		tx_code <= cd;
		tx_final <= fn;
		tx_has_fif <= (fq.size() != 0);
		tx_rate <= rt;
		@(posedge ref_clk);
		tx_req <= 1'b0;
	endtask : req
	task automatic wait_done;
		int k;
		k = 0;
		while (tx_done !== 1'b1 && k < 4000) begin
			@(posedge ref_clk);
			k++;
		end
		chk("tx_done", k < 4000, 1);
		repeat (2) @(posedge ref_clk);
	endtask : wait_done
	task automatic tx(logic [7:0] cd, logic fn, logic [1:0] rt);
		P.q.delete();
		foreach (fq[i]) push(fq[i], i == fq.size() - 1);
		fif_in_valid <= 1'b0;
		if (fq.size() == FIFO_D) begin
			@(posedge ref_clk);
			chk("fifo full", fif_in_ready, 0);
		end
		req(cd, fn, rt);
		wait_done();
	endtask : tx
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{tx_req, tx_final, tx_has_fif, fif_in_last, fif_in_valid} = '0;
		{rx_bit, rx_bit_valid, rx_tcf_active, tx_code, tx_rate} = '0;
		fif_in_data = 8'h00;
		rst_b = 1'b0;
		void'($urandom(32'h0A3A903F));
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk("reset", {tx_busy, tx_bit_valid, mdm_train, mdm_rate}, 0);
		// direction bit still clear: request bit7 is overridden
		repeat (1 + $urandom_range(2)) fq.push_back(8'($urandom));
		fn0 = 1'($urandom);
		tx(8'hB1, fn0, 2'h0);
		mk(8'h31, fn0, 1'b0);
		cmp("mcf x0");
		c_rej = 0;
		fq = {};
		req(8'hFF, 1'b1, 2'h0);
		repeat (3) @(posedge ref_clk);
		chk("reject", {c_rej[3:0], tx_busy}, 5'h02);
		c_ok = 0;
		c_err = 0;
		rx_frm(8'h01, 1'b0);
		chk("rx dis", {c_ok[3:0], rx_fcf, rx_final}, 13'h0203);
		rx_frm(8'h01, 1'b1);
		rx_frm(8'h7F, 1'b0);
		chk("rx bad", {c_ok[3:0], c_err[3:0]}, 8'h12);
		// dcs at every rate, x now set by the received dis
		for (int r = 0; r < 4; r++) begin
			n_tr = 0;
			n_tc = 0;
			P.ones = 0;
			tx(8'h41, 1'b1, 2'(r));
			mk(8'hC1, 1'b1, 1'b0);
			cmp("dcs");
			repeat (T2 + TT + 10) @(posedge ref_clk);
			chk("train", n_tr, e_tr[r]);
			chk("tcf len", n_tc, r == 3 ? 0 : TT);
			chk("rate", {mdm_rate, mdm_v34}, {2'(r), r == 3});
			chk("tcf ones", P.ones, 0);
		end
		// tcf reception clean, then with one error bit
		for (int f = 0; f < 2; f++) begin
			{c_pas, c_fai} = '0;
			P.q.delete();
			rx_tcf_active <= 1'b1;
			rx_oct(8'h00);
			rx_oct(f ? 8'h10 : 8'h00);
			rx_end();
			wait_done();
			chk("tcf verdict", {c_pas[1:0], c_fai[1:0]}, f ? 4'h1 : 4'h4);
			mk(f ? 8'hA2 : 8'hA1, 1'b1, 1'b0);
			cmp("tcf reply");
		end
		// fill the fifo to refusal while the modem stalls at random
		repeat (FIFO_D) fq.push_back(8'($urandom));
		tx(8'h31, 1'b1, 2'h0);
		mk(8'hB1, 1'b1, 1'b0);
		cmp("fifo frame");
		chk("fifo drained", fif_in_ready, 1);
		fq = {};
		tx(8'h01, 1'b1, 2'h0);
		mk(8'h01, 1'b1, 1'b0);
		cmp("dis");
		rx_frm(8'hC1, 1'b0);
		tx(8'hB1, 1'b0, 2'h0);
		mk(8'h31, 1'b0, 1'b0);
		cmp("x cleared");
		results();
	end
	// watchdog sized well beyond the sequence above
	initial begin
		#240000;
		n_errors++;
		results();
	end
endmodule : fcft_core_tb
